// file: logic/fps_top.sv
/*
 * Front-panel scanner: switch matrix, pot and probe scan, LED latch,
 * two 1 kHz reference waves and the serial link to the host.
 * Assumes an external ADC with start/done handshake, analog muxes
 * steered by the select outputs, and an 8-bit LED latch on led_latch_o.
 */
// How it works
// - Matrix is nine rows by eight columns
// - Rows driven low one at a time
// - Columns sampled per row, compared to stored
// - Low column means closed, high means open
// - Changes, and each probe's first reading, reported to host
// - Compare output one: 1 kHz square wave
// - Compare output two: 1 kHz reference
// - Five LEDs on an eight-bit latch
// - Host LED id maps to one bit
// - Mux selects choose pot or probe input
// - Ten pot inputs across two muxes
// - Pot value stored, delta computed and reported
// - Four rotary pots from wiper pairs
// - Two end-stopped intensity pots, one input each
// - Four probe inputs classified and reported
// - Serial link, 9600 baud, async 8N1
`timescale 1ns/1ps
`default_nettype none
module fps_top #(
  parameter int HALF_CYC = fps_pkg::REF_HALF_CYC, // Reference half period
  parameter int BIT_CYC  = fps_pkg::BIT_CYC       // Serial bit time
) (
  input  wire logic       clk_i,                    // 100 MHz clock
  input  wire logic       reset_n_i,                // Sync reset, low
  output logic      [8:0] row_n_o,                  // Row drive, low=active
  input  wire logic [7:0] col_i,                    // Column sense pins
  output logic      [2:0] mux_chan_o,               // Mux channel
  output logic            mux_bank_o,               // 0 first mux, 1 second
  output logic            probe_mode_o,             // 1 probe, 0 pot
  output logic            adc_start_o,              // Conversion start
  input  wire logic       adc_done_i,               // Conversion done
  input  wire logic [7:0] adc_data_i,               // Conversion result
  output logic      [7:0] led_latch_o,              // LED latch bits
  output logic            probe_comp_square_wave_o, // First reference
  output logic            reference_a_o,            // Second reference
  input  wire logic       ser_rx_i,                 // Line from host
  output logic            ser_tx_o                  // Line to host
);
  // ------------------------------------------------------------------
  // Serial port
  // ------------------------------------------------------------------
  fps_ser_if ser ();

  fps_uart #(.BIT_CYC(BIT_CYC)) u_uart (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .ser_rx_i  (ser_rx_i),
    .ser_tx_o  (ser_tx_o),
    .ser       (ser)
  );

  // ------------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------------
  logic [7:0] col_m, col_s; // Columns
  logic [7:0] adc_m, adc_s; // ADC result
  logic       done_m, done_s, done_q;

  // Two flops on each column, ADC data and done pin before use; done_q only for the edge
  always_ff @(posedge clk_i) begin
    col_m  <= col_i;
    col_s  <= col_m;
    adc_m  <= adc_data_i;
    adc_s  <= adc_m;
    done_m <= adc_done_i;
    done_s <= done_m;
    done_q <= done_s;
  end

  wire done_rise = done_s & ~done_q;

  // ------------------------------------------------------------------
  // Scanner state
  // ------------------------------------------------------------------
  fps_pkg::fps_state_e state, resume; // Current, and after a report
  logic [3:0] row_idx;                // Row under scan
  logic [3:0] ana_idx;                // Analog step 0..13
  logic [7:0] settle;                 // Row settle timer
  logic [7:0] sample;                 // Last conversion
  logic [7:0] wiper_a;                // First wiper of a rotary pot
  logic [9:0] slot_ok;                // Stored value is valid
  logic [7:0] rep_tag, rep_val;       // Pending report bytes
  logic [7:0] sw_stable [fps_pkg::ROWS]; // Accepted closures
  logic [7:0] sw_last   [fps_pkg::ROWS]; // Previous raw sample
  logic [1:0] sw_cnt    [fps_pkg::ROWS]; // Equal-scan count
  logic [7:0] old_val;                // Stored value of this slot

  // ------------------------------------------------------------------
  // Switch decode
  // ------------------------------------------------------------------
  wire       row_on   = (state == fps_pkg::ST_ROW) | (state == fps_pkg::ST_SAMPLE);
  wire [7:0] sw_raw   = ~col_s;
  wire       sw_same  = sw_raw == sw_last[row_idx];
  wire [1:0] next_cnt = !sw_same ? 2'h0 :
                        sw_cnt[row_idx] == 2'(fps_pkg::DEB_SCANS - 1) ?
                        sw_cnt[row_idx] : sw_cnt[row_idx] + 2'h1;
  // Accept only after DEB_SCANS equal scans that differ from stored
  wire       sw_accept = (next_cnt == 2'(fps_pkg::DEB_SCANS - 1)) &
                         (sw_raw != sw_stable[row_idx]);
  wire       row_last  = row_idx == 4'(fps_pkg::ROWS - 1);
  wire [8:0] row_sel   = 9'h001 << row_idx;

  assign row_n_o = row_on ? ~row_sel : 9'h1ff;

  // ------------------------------------------------------------------
  // Analog decode
  // ------------------------------------------------------------------
  wire       is_rot  = ana_idx < 4'h8;
  wire       is_prb  = ana_idx >= 4'(fps_pkg::POTS);
  wire       rot_a   = is_rot & ~ana_idx[0];
  wire       ana_last = ana_idx == 4'(fps_pkg::POTS + fps_pkg::PROBES - 1);
  wire [3:0] slot    = is_rot ? {1'b0, ana_idx[3:1]} : ana_idx - 4'h4;
  wire       a_mid   = (wiper_a >= fps_pkg::ROT_LO) & (wiper_a < fps_pkg::ROT_HI);
  // Use wiper A in its clean range, else wiper B shifted half a turn
  wire [7:0] rot_val = a_mid ? wiper_a : sample + fps_pkg::HALF_TURN;
  wire [7:0] prb_cls = sample < fps_pkg::PRB_TH1 ? 8'h00 :
                       sample < fps_pkg::PRB_TH2 ? 8'h01 :
                       sample < fps_pkg::PRB_TH3 ? 8'h02 : 8'h03;
  wire [7:0] new_val = is_prb ? prb_cls : is_rot ? rot_val : sample;
  wire [7:0] delta   = new_val - old_val;
  wire       have    = slot_ok[slot];
  // Pots report only a change; a probe also reports its first reading
  wire       ana_rep = have ? (new_val != old_val) : is_prb;
  wire       mem_we  = state == fps_pkg::ST_CMP;

  assign probe_mode_o = is_prb;
  assign mux_bank_o   = is_rot & ana_idx[0];
  assign mux_chan_o   = is_rot ? ana_idx[3:1] :
                        is_prb ? 3'(ana_idx - 4'ha) : 3'(ana_idx - 4'h4);
  assign adc_start_o  = state == fps_pkg::ST_ADC;

  fps_mem #(.W(8), .AW(4)) u_mem (
    .clk_i   (clk_i),
    .we_i    (mem_we),
    .waddr_i (slot),
    .wdata_i (new_val),
    .raddr_i (slot),
    .rdata_o (old_val)
  );

  // Next step after a row or analog input is done
  wire fps_pkg::fps_state_e row_next = row_last ? fps_pkg::ST_ADC : fps_pkg::ST_ROW;
  wire fps_pkg::fps_state_e ana_next = ana_last ? fps_pkg::ST_ROW : fps_pkg::ST_ADC;
  wire [3:0] next_row = row_last ? 4'h0 : row_idx + 4'h1;
  wire [3:0] next_ana = ana_last ? 4'h0 : ana_idx + 4'h1;

  assign ser.tx_valid = (state == fps_pkg::ST_SEND0) | (state == fps_pkg::ST_SEND1);
  assign ser.tx_data  = state == fps_pkg::ST_SEND0 ? rep_tag : rep_val;

  // ------------------------------------------------------------------
  // Scan sequencer
  // ------------------------------------------------------------------
  // Scanning stalls while a report drains, so no event is ever dropped
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      state   <= fps_pkg::ST_ROW;
      resume  <= fps_pkg::ST_ROW;
      row_idx <= 4'h0;
      ana_idx <= 4'h0;
      settle  <= 8'h00;
      sample  <= 8'h00;
      wiper_a <= 8'h00;
      slot_ok <= 10'h000;
      rep_tag <= 8'h00;
      rep_val <= 8'h00;
      for (int r = 0; r < fps_pkg::ROWS; r++) begin
        sw_stable[r] <= 8'h00;
        sw_last[r]   <= 8'h00;
        sw_cnt[r]    <= 2'h0;
      end
    end else begin
      case (state)
        fps_pkg::ST_ROW: begin     // Let the row settle
          settle <= settle + 8'h01;
          if (settle == 8'(fps_pkg::SETTLE_CYC - 1)) begin
            settle <= 8'h00;
            state  <= fps_pkg::ST_SAMPLE;
          end
        end
        fps_pkg::ST_SAMPLE: begin  // Compare columns with stored row
          sw_last[row_idx] <= sw_raw;
          sw_cnt[row_idx]  <= next_cnt;
          row_idx          <= next_row;
          if (sw_accept) begin
            sw_stable[row_idx] <= sw_raw;
            rep_tag <= {fps_pkg::TAG_SW, row_idx};
            rep_val <= sw_raw;
            resume  <= row_next;
            state   <= fps_pkg::ST_SEND0;
          end else begin
            state <= row_next;
          end
        end
        fps_pkg::ST_ADC: begin     // Start pulse goes out this cycle
          state <= fps_pkg::ST_WAIT;
        end
        fps_pkg::ST_WAIT: begin    // Wait for the converter
          if (done_rise) begin
            sample <= adc_s;
            if (rot_a) begin
              wiper_a <= adc_s;
              ana_idx <= next_ana;
              state   <= ana_next;
            end else begin
              state <= fps_pkg::ST_READ;
            end
          end
        end
        fps_pkg::ST_READ: begin    // Stored value arrives next cycle
          state <= fps_pkg::ST_CMP;
        end
        fps_pkg::ST_CMP: begin     // Store new value, maybe report
          slot_ok[slot] <= 1'b1;
          ana_idx       <= next_ana;
          if (ana_rep) begin
            rep_tag <= {is_prb ? fps_pkg::TAG_PRB : fps_pkg::TAG_POT, slot};
            rep_val <= is_prb ? new_val : delta;
            resume  <= ana_next;
            state   <= fps_pkg::ST_SEND0;
          end else begin
            state <= ana_next;
          end
        end
        fps_pkg::ST_SEND0: begin   // Tag byte
          if (ser.tx_ready) begin
            state <= fps_pkg::ST_SEND1;
          end
        end
        fps_pkg::ST_SEND1: begin   // Value byte
          if (ser.tx_ready) begin
            state <= resume;
          end
        end
        default: begin
          state <= fps_pkg::ST_ROW;
        end
      endcase
    end
  end

  // ------------------------------------------------------------------
  // LED latch
  // ------------------------------------------------------------------
  wire [2:0] led_id = ser.rx_data[2:0];
  wire       led_ok = ser.rx_valid & (led_id < 3'(fps_pkg::LEDS));
  wire [2:0] led_b  = fps_pkg::LED_MAP[led_ok ? led_id : 3'h0];

  // Unknown ids are ignored; spare bits stay high
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      led_latch_o <= fps_pkg::LED_RST;
    end else if (led_ok) begin
      led_latch_o[led_b] <= ~ser.rx_data[fps_pkg::LED_ON_B];
    end
  end

  // ------------------------------------------------------------------
  // Reference waves
  // ------------------------------------------------------------------
  logic [15:0] ref_cnt; // Half-period counter
  wire         ref_end = ref_cnt == 16'(HALF_CYC - 1);
  wire         ref_mid = ref_cnt == 16'(HALF_CYC / 2 - 1);

  // Second wave toggles mid-way: same rate, a quarter period earlier
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      ref_cnt                  <= 16'h0000;
      probe_comp_square_wave_o <= 1'b0;
      reference_a_o            <= 1'b0;
    end else begin
      ref_cnt <= ref_end ? 16'h0000 : ref_cnt + 16'h0001;
      if (ref_end) begin
        probe_comp_square_wave_o <= ~probe_comp_square_wave_o;
      end
      if (ref_mid) begin
        reference_a_o <= ~reference_a_o;
      end
    end
  end

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  a_row_one_low: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    $countones(~row_n_o) <= 1 && (row_on || row_n_o == 9'h1ff))
    else $error("more than one row driven");
  a_row_order: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    state == fps_pkg::ST_SAMPLE |=> row_idx == ($past(row_idx) == 4'h8 ? 4'h0
                                                : $past(row_idx) + 4'h1))
    else $error("row order broken");
  a_sw_changed: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    state == fps_pkg::ST_SAMPLE && sw_accept |=> state == fps_pkg::ST_SEND0
      && rep_val == ~$past(col_s) && rep_val != $past(sw_stable[row_idx]))
    else $error("switch report wrong");
  a_pot_delta: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    state == fps_pkg::ST_CMP && !is_prb && have && new_val != old_val
      |=> state == fps_pkg::ST_SEND0 && rep_val == $past(new_val) - $past(old_val)
      ##1 (state == fps_pkg::ST_SEND1) == $past(ser.tx_ready))
    else $error("pot delta wrong");
  a_led_bit: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    led_ok |=> (led_latch_o ^ $past(led_latch_o)) == 8'h00 ||
               (led_latch_o ^ $past(led_latch_o)) == (8'h01 << $past(led_b)))
    else $error("led changed wrong bits");
  a_led_low_on: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    led_ok && ser.rx_data[fps_pkg::LED_ON_B] |=> !led_latch_o[$past(led_b)])
    else $error("led not lit low");
  a_led_spare: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    led_latch_o[7:5] == 3'h7)
    else $error("spare latch bit moved");
  a_wave_one: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    ref_end |=> probe_comp_square_wave_o != $past(probe_comp_square_wave_o)
      ##1 $stable(probe_comp_square_wave_o))
    else $error("wave one timing");
  a_wave_two: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    !ref_mid |=> $stable(reference_a_o))
    else $error("wave two toggled early");
  a_mux_mode: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    adc_start_o |-> probe_mode_o == (ana_idx >= 4'ha) && (probe_mode_o -> !mux_bank_o))
    else $error("mux mode wrong");
endmodule
`default_nettype wire

// file: logic/fps_pkg.sv
/*
 * Constants, field layouts and state codes of the front-panel scanner.
 * Assumes a 100 MHz system clock; shared by the top and its helpers.
 */
`default_nettype none
package fps_pkg;
  // ------------------------------------------------------------------
  // Clock and timing
  // ------------------------------------------------------------------
  localparam int CLK_HZ       = 100_000_000;          // System clock
  localparam int BAUD         = 9600;                 // Serial link rate
  localparam int BIT_CYC      = CLK_HZ / BAUD;        // Cycles per bit
  localparam int REF_HZ       = 1000;                 // Reference waves
  localparam int REF_HALF_CYC = CLK_HZ / (2 * REF_HZ); // Half period
  localparam int SETTLE_NS    = 2000;                 // Row settle time
  localparam int SETTLE_CYC   = (SETTLE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

  // ------------------------------------------------------------------
  // Panel geometry
  // ------------------------------------------------------------------
  localparam int ROWS      = 9;  // Row drive lines
  localparam int COLS      = 8;  // Column sense lines
  localparam int POTS      = 10; // Pot inputs
  localparam int PROBES    = 4;  // Probe-code inputs
  localparam int DEB_SCANS = 3;  // Equal scans before a switch change

  // ------------------------------------------------------------------
  // Report tags (upper nibble of the first byte)
  // ------------------------------------------------------------------
  localparam logic [3:0] TAG_SW  = 4'h1; // Switch row change
  localparam logic [3:0] TAG_POT = 4'h2; // Pot delta
  localparam logic [3:0] TAG_PRB = 4'h3; // Probe type

  // ------------------------------------------------------------------
  // Analog scan constants
  // ------------------------------------------------------------------
  localparam logic [7:0] ROT_LO    = 8'h40; // Wiper A usable window low
  localparam logic [7:0] ROT_HI    = 8'hc0; // Wiper A usable window high
  localparam logic [7:0] HALF_TURN = 8'h80; // Offset between the wipers
  localparam logic [7:0] PRB_TH1   = 8'h40; // Probe class thresholds
  localparam logic [7:0] PRB_TH2   = 8'h80;
  localparam logic [7:0] PRB_TH3   = 8'hc0;

  // ------------------------------------------------------------------
  // LED latch and command byte
  // ------------------------------------------------------------------
  localparam int         LEDS     = 5;     // Indicator count
  localparam logic [7:0] LED_RST  = 8'hff; // All dark after reset
  localparam int         LED_ON_B = 3;     // Command bit: 1 lights
  localparam logic [2:0] LED_MAP [LEDS] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4};

  // Scanner states, one-hot
  typedef enum logic [7:0] {
    ST_ROW    = 8'h01,
    ST_SAMPLE = 8'h02,
    ST_ADC    = 8'h04,
    ST_WAIT   = 8'h08,
    ST_READ   = 8'h10,
    ST_CMP    = 8'h20,
    ST_SEND0  = 8'h40,
    ST_SEND1  = 8'h80
  } fps_state_e;
endpackage
`default_nettype wire

// file: logic/fps_ser_if.sv
/*
 * Byte carrier between the scanner core and its serial port.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
interface fps_ser_if;
  logic [7:0] tx_data;  // Byte to send
  logic       tx_valid; // Byte offered
  logic       tx_ready; // Transmitter idle
  logic [7:0] rx_data;  // Byte received
  logic       rx_valid; // One-cycle receive pulse
  modport ctl (output tx_data, tx_valid, input tx_ready, rx_data, rx_valid);
  modport phy (input tx_data, tx_valid, output tx_ready, rx_data, rx_valid);
endinterface
`default_nettype wire

// file: logic/fps_mem.sv
/*
 * Small store of previous pot values and probe classes.
 * Assumes one write and one read port; read data are registered.
 */
`timescale 1ns/1ps
`default_nettype none
module fps_mem #(
  parameter int W  = 8, // Word width
  parameter int AW = 4  // Address width
) (
  input  wire logic          clk_i,   // System clock
  input  wire logic          we_i,    // Write strobe
  input  wire logic [AW-1:0] waddr_i, // Write address
  input  wire logic [W-1:0]  wdata_i, // Write data
  input  wire logic [AW-1:0] raddr_i, // Read address
  output logic      [W-1:0]  rdata_o  // Read data, one cycle late
);
  logic [W-1:0] mem [2**AW]; // Storage, no reset: slots carry valid bits

  // Write and registered read
  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
    rdata_o <= mem[raddr_i];
  end
endmodule
`default_nettype wire

// file: logic/fps_uart.sv
/*
 * Asynchronous 8N1 serial port: transmitter and receiver.
 * Assumes the line idles high; the receive pin is asynchronous.
 */
`timescale 1ns/1ps
`default_nettype none
module fps_uart #(
  parameter int BIT_CYC = fps_pkg::BIT_CYC // Cycles per bit
) (
  input  wire logic clk_i,     // System clock
  input  wire logic reset_n_i, // Synchronous reset, active low
  input  wire logic ser_rx_i,  // Serial line in
  output logic      ser_tx_o,  // Serial line out
  fps_ser_if.phy    ser        // Byte side
);
  // ------------------------------------------------------------------
  // Transmitter
  // ------------------------------------------------------------------
  logic [9:0]  tx_sh;   // Stop, data, start; LSB on the line
  logic [3:0]  tx_left; // Bits still to send
  logic [15:0] tx_cnt;  // Bit timer
  wire         tx_take = ser.tx_valid & ser.tx_ready;
  wire         tx_tick = tx_cnt == 16'(BIT_CYC - 1);

  assign ser.tx_ready = tx_left == 4'h0;
  assign ser_tx_o     = tx_sh[0];

  // Load a frame, then shift one bit per bit time
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      tx_sh   <= 10'h3ff;
      tx_left <= 4'h0;
      tx_cnt  <= 16'h0000;
    end else if (tx_take) begin
      tx_sh   <= {1'b1, ser.tx_data, 1'b0};
      tx_left <= 4'ha;
      tx_cnt  <= 16'h0000;
    end else if (tx_left != 4'h0) begin
      tx_cnt <= tx_tick ? 16'h0000 : tx_cnt + 16'h0001;
      if (tx_tick) begin
        tx_sh   <= {1'b1, tx_sh[9:1]};
        tx_left <= tx_left - 4'h1;
      end
    end
  end

  // ------------------------------------------------------------------
  // Receiver
  // ------------------------------------------------------------------
  logic        rx_m, rx_s; // Two-stage synchroniser
  logic        rx_busy;    // Inside a frame
  logic [3:0]  rx_bit;     // 0 start, 1..8 data, 9 stop
  logic [15:0] rx_cnt;     // Bit timer
  logic [7:0]  rx_sh;      // Data assembly, LSB first
  wire         rx_tick = rx_cnt == (rx_bit == 4'h0 ? 16'(BIT_CYC / 2 - 1)
                                                   : 16'(BIT_CYC - 1));

  // Sample each bit at its centre; a false start or bad stop is dropped
  always_ff @(posedge clk_i) begin
    rx_m <= ser_rx_i;
    rx_s <= rx_m;
    if (!reset_n_i) begin
      rx_busy      <= 1'b0;
      rx_bit       <= 4'h0;
      rx_cnt       <= 16'h0000;
      rx_sh        <= 8'h00;
      ser.rx_valid <= 1'b0;
      ser.rx_data  <= 8'h00;
    end else begin
      ser.rx_valid <= 1'b0;
      if (!rx_busy) begin
        rx_busy <= !rx_s;
        rx_bit  <= 4'h0;
        rx_cnt  <= 16'h0000;
      end else if (!rx_tick) begin
        rx_cnt <= rx_cnt + 16'h0001;
      end else begin
        rx_cnt <= 16'h0000;
        rx_bit <= rx_bit + 4'h1;
        if (rx_bit == 4'h0) begin
          rx_busy <= !rx_s;
        end else if (rx_bit == 4'h9) begin
          rx_busy      <= 1'b0;
          ser.rx_valid <= rx_s;
          ser.rx_data  <= rx_sh;
        end else begin
          rx_sh <= {rx_s, rx_sh[7:1]};
        end
      end
    end
  end
endmodule
`default_nettype wire

// file: dv/fps_host.sv
/* Host model on the serial link: 8N1 byte sender and receiver.
   Assumes BC clock cycles a bit and a line idling high. */
`timescale 1ns/1ps
`default_nettype none
module fps_host #(
  parameter int BC = 16 // Cycles per bit
) (
  input  wire logic clk_i,  // System clock
  input  wire logic line_i, // From device transmitter
  output logic      line_o  // To device receiver
);
  logic [7:0] q [$]; // Bytes received, in order
  logic [7:0] b;     // Receive shift
  initial line_o = 1'b1;
  // Start, LSB first, stop; bits move just after an edge
  task automatic send(input logic [7:0] d);
    for (int i = 0; i < 10; i++) begin
      @(posedge clk_i);
      #1 line_o = (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : d[i-1];
      repeat (BC - 1) @(posedge clk_i);
    end
  endtask
  // Centre sampling so edge jitter of the sender does no harm
  always begin
    @(negedge line_i);
    repeat (BC / 2) @(posedge clk_i);
    for (int i = 0; i < 8; i++) begin
      repeat (BC) @(posedge clk_i);
      b[i] = line_i;
    end
    repeat (BC) @(posedge clk_i);
    q.push_back(b);
  end
endmodule
`default_nettype wire

// file: dv/front_panel_scanner_bench.sv
/* Bench of the front-panel scanner: host model, switch matrix,
   ADC responder. Assumes shortened wave and bit parameters. */
`timescale 1ns/1ps
`default_nettype none
module front_panel_scanner_bench;
  logic clk_i, reset_n_i, adc_done_i, adc_start_o, ser_rx_i, ser_tx_o;
  logic mux_bank_o, probe_mode_o, probe_comp_square_wave_o, reference_a_o;
  logic [8:0] row_n_o;
  logic [7:0] col_i, adc_data_i, adc_val, led_latch_o, exp_led, sw_m, c;
  logic [2:0] mux_chan_o;
  int error_cnt, checks, sw_r, n, ak;
  fps_top #(.HALF_CYC(20), .BIT_CYC(16)) DUT (.clk_i, .reset_n_i, .row_n_o,
    .col_i, .mux_chan_o, .mux_bank_o, .probe_mode_o, .adc_start_o,
    .adc_done_i, .adc_data_i, .led_latch_o, .probe_comp_square_wave_o,
    .reference_a_o, .ser_rx_i, .ser_tx_o);
  fps_host #(.BC(16)) host (.clk_i, .line_i(ser_tx_o), .line_o(ser_rx_i));
  // Pressed switch pulls its column low while its row is driven
  assign col_i = (row_n_o[sw_r] !== 1'b0) ? 8'hff : ~sw_m;
  initial begin clk_i = 0; forever #5 clk_i = ~clk_i; end
  // ADC answers three cycles after start; data settle before done.
  // Selects are held against the scan order at every start.
  always @(posedge clk_i) if (adc_start_o === 1'b1) begin
    #1 adc_done_i = 0;
    adc_data_i = adc_val;
    chk("mux", {probe_mode_o, mux_bank_o, mux_chan_o}, exp_mux(ak));
    ak++;
    repeat (3) @(posedge clk_i);
    #1 adc_done_i = 1;
  end
  task automatic chk(input string s, input logic [8:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", s, exp, seen);
    end
  endtask
  function automatic int cnt(input logic [7:0] a, d);
    cnt = 0;
    for (int i = 0; i + 1 < host.q.size(); i += 2)
      if (host.q[i] === a && host.q[i+1] === d) cnt++;
  endfunction
  // Expected {probe, bank, channel} of analog step k: wipers, stopped pots, probes
  function automatic logic [8:0] exp_mux(input int k);
    k = k % 14;
    exp_mux = (k < 8) ? {4'h0, 1'b0, 1'(k), 3'(k / 2)} :
              (k < 10) ? {4'h0, 1'b0, 1'b0, 3'(k - 4)} :
                         {4'h0, 1'b1, 1'b0, 3'(k - 10)};
  endfunction
  task automatic wait_pair(input logic [7:0] a, d, input string s);
    for (int i = 0; i < 15000 && cnt(a, d) == 0; i++) @(posedge clk_i);
    chk(s, cnt(a, d), 1);
    #1;
  endtask
  task automatic finish_test();
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // One row low at a time, or none
  always @(posedge clk_i) if (reset_n_i === 1'b1 && row_n_o !== 9'h1ff)
    chk("rows", $countones(~row_n_o), 1);
  initial begin repeat (90000) @(posedge clk_i); error_cnt++; finish_test(); end
  initial begin
    n = $urandom(69);
    reset_n_i = 0; adc_done_i = 0; adc_data_i = 0; adc_val = 8'h50;
    sw_r = 0; sw_m = 0; exp_led = 8'hff;
    repeat (3) @(posedge clk_i);
    #1 reset_n_i = 1;
    chk("led", led_latch_o, 8'hff);
    chk("row", row_n_o, 9'h1fe);
    @(posedge probe_comp_square_wave_o);
    n = 0;
    do begin @(posedge clk_i); #1 n++; end while (probe_comp_square_wave_o && n < 99);
    chk("half", n, 20);
    n = 0;
    c[0] = reference_a_o;
    repeat (80) begin
      @(posedge clk_i);
      #1 if (reference_a_o !== c[0]) n++;
      c[0] = reference_a_o;
    end
    chk("ref", n, 4);
    for (int k = 0; k < 12; k++) begin
      c = (k == 0) ? 8'h0c : (k == 1) ? 8'h0d : {4'h0, 4'($urandom)};
      host.send(c);
      if (c[2:0] < 5) exp_led[c[2:0]] = ~c[3];
      @(posedge clk_i);
      chk("led", led_latch_o, exp_led);
    end
    wait_pair(8'h36, 8'h01, "probe");
    adc_val = 8'h60;
    wait_pair(8'h20, 8'h10, "rotary");
    wait_pair(8'h24, 8'h10, "stopped");
    sw_r = $urandom % 9;
    sw_m = 8'(($urandom % 255) + 1);
    wait_pair({4'h1, 4'(sw_r)}, sw_m, "press");
    chk("probe once", cnt(8'h36, 8'h01), 1);
    sw_m = 0;
    wait_pair({4'h1, 4'(sw_r)}, 8'h00, "release");
    finish_test();
  end
endmodule
`default_nettype wire
